// File: bench/sat_line_model.sv
/*
  Far end of the serial line: makes the bit clock and samples the serial output once per bit.
  Assumes the transmitter runs at a 1X factor from this clock, so that one bit clock period is one bit.
*/
`timescale 1ns/100ps
`default_nettype none
module sat_line_model (
  input wire logic i_mclk,
  input wire logic i_txd,
  output logic o_tick,
  output logic o_sampled,
  output logic o_line_bit
);
  logic [3:0] phase_ff = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // The bit clock runs free; sampling just before its next rise keeps the read clear of the
  // transmitter's synchroniser delay, which costs some cycles after each rise.
  always @(posedge i_mclk) begin
    phase_ff <= phase_ff + 4'h1;
  end
  assign o_tick = ~phase_ff[3];
  assign o_sampled = (phase_ff == 4'hE);
  assign o_line_bit = i_txd;
endmodule
`default_nettype wire

// File: bench/sat_transmitter_chk.sv
/*
  Port checker for the serial transmitter, bound to its top module.
  Assumes both bit clock inputs carry the same tick and one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module sat_transmitter_chk (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire i_ce_n,
  input wire i_rw,
  input wire i_register_select_high,
  input wire i_register_select_low,
  input wire [7:0] i_data,
  input wire [7:0] o_data,
  input wire o_data_oe,
  input wire i_cts_n,
  input wire i_ext_tick,
  input wire i_int_tick,
  input wire o_txd,
  input wire o_tx_holding_ready_n,
  input wire o_tx_empty_or_modem_change_n
);
  logic [3:0] ce_age_ff;
  logic [3:0] tick_age_ff;
  logic tick_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last host access and the last bit clock rise; they saturate so that
  // a long quiet spell never wraps round and looks recent.
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ce_age_ff <= 4'hF;
      tick_age_ff <= 4'hF;
      tick_prev_ff <= 1'b0;
    end else begin
      ce_age_ff <= !i_ce_n ? 4'h0 : ((ce_age_ff == 4'hF) ? 4'hF : ce_age_ff + 4'h1);
      tick_age_ff <= (i_ext_tick && !tick_prev_ff) ? 4'h0 : ((tick_age_ff == 4'hF) ? 4'hF : tick_age_ff + 4'h1);
      tick_prev_ff <= i_ext_tick | i_int_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  a_bus_released: assert property (i_ce_n [*6] |-> !o_data_oe)
    else $error("Data bus driven with chip enable high.");
  a_write_undriven: assert property ((!i_ce_n && i_rw) [*6] |-> !o_data_oe)
    else $error("Data bus driven during a write.");
  a_read_drives: assert property ((!i_ce_n && !i_rw) [*6] |-> o_data_oe)
    else $error("Data bus not driven during a read.");
  a_data_quiet: assert property ($changed(o_data) |-> ce_age_ff < 4'h8)
    else $error("Read data changed without an access.");
  a_reset_idle: assert property ($fell(i_sys_rst) |-> o_txd && o_tx_holding_ready_n && o_tx_empty_or_modem_change_n)
    else $error("Outputs not at rest when reset ends.");
  a_txd_on_tick: assert property ($changed(o_txd) |-> tick_age_ff < 4'hC || ce_age_ff < 4'hC)
    else $error("Serial output moved away from a bit boundary.");
  a_ready_negate: assert property ($fell(i_ce_n) && i_rw && !i_register_select_high && !i_register_select_low
    && !o_tx_holding_ready_n |-> ##[3:10] o_tx_holding_ready_n)
    else $error("Ready stayed asserted after a holding write.");
  a_ready_cause: assert property ($rose(o_tx_holding_ready_n) |-> ce_age_ff < 4'h8)
    else $error("Ready negated without a host access.");
  a_empty_cause: assert property ($rose(o_tx_empty_or_modem_change_n) |-> ce_age_ff < 4'h8)
    else $error("Empty flag cleared without a host access.");
endmodule
bind sat_transmitter sat_transmitter_chk u_sat_transmitter_chk (.i_mclk, .i_sys_rst, .i_ce_n, .i_rw,
  .i_register_select_high, .i_register_select_low, .i_data, .o_data, .o_data_oe, .i_cts_n, .i_ext_tick,
  .i_int_tick, .o_txd, .o_tx_holding_ready_n, .o_tx_empty_or_modem_change_n);
`default_nettype wire

// File: bench/sat_transmitter_test.sv
/*
  Self-checking bench for the serial transmitter: host register tasks and serial line checks.
  Assumes the line model makes the bit clock and the mode two register keeps the external source.
*/
`timescale 1ns/100ps
`default_nettype none
module sat_transmitter_test;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_ce_n = 1'b1;
  logic i_rw = 1'b0;
  logic i_register_select_high = 1'b0;
  logic i_register_select_low = 1'b0;
  logic i_cts_n = 1'b0;
  logic [7:0] i_data = 8'h00;
  logic [7:0] o_data;
  logic o_data_oe, i_ext_tick, o_txd, o_tx_holding_ready_n, o_tx_empty_or_modem_change_n, line_sampled, line_bit;
  logic b;
  logic [31:0] f;
  logic [7:0] q;
  logic [7:0] chars [4] = '{8'h13, 8'h2D, 8'h5B, 8'hA5};
  logic [7:0] modes [4] = '{8'h8C, 8'h0C, 8'h4C, 8'h8C};
  logic [7:0] cmds [4] = '{8'h01, 8'h01, 8'h01, 8'h09};
  logic [31:0] fills [4] = '{{9'h1FF, 8'h96, 8'h96, 7'h55}, {9'h1FF, 8'h3C, 8'h96, 7'h55},
    {9'h1FF, 8'h96, 8'h10, 7'h55}, {9'h1FF, 8'h96, 8'hAA, 7'h08}};
  int err_count = 0;
  int samples_checked = 0;

  always #20 i_mclk = ~i_mclk;

  sat_transmitter u_sat_transmitter (.i_mclk, .i_sys_rst, .i_ce_n, .i_rw, .i_register_select_high,
    .i_register_select_low, .i_data, .o_data, .o_data_oe, .i_cts_n, .i_ext_tick, .i_int_tick(i_ext_tick),
    .o_txd, .o_tx_holding_ready_n, .o_tx_empty_or_modem_change_n);
  sat_line_model u_sat_line_model (.i_mclk, .i_txd(o_txd), .o_tick(i_ext_tick), .o_sampled(line_sampled),
    .o_line_bit(line_bit));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // One access per chip enable pulse, held long enough for the three-flop synchroniser.
  task automatic access(input logic [1:0] sel, input logic wr_n, input logic [7:0] d, output logic [7:0] r);
    @(posedge i_mclk);
    #1 {i_register_select_high, i_register_select_low} = sel;
    i_rw = wr_n;
    i_data = d;
    i_ce_n = 1'b0;
    repeat (7) @(posedge i_mclk);
    r = o_data;
    #1 i_ce_n = 1'b1;
    repeat (4) @(posedge i_mclk);
  endtask

  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    logic [7:0] r;
    access(sel, 1'b1, d, r);
  endtask

  task automatic rdc(input logic [1:0] sel, input string what, input logic [7:0] exp);
    logic [7:0] r;
    access(sel, 1'b0, 8'h00, r);
    check(what, exp, r);
  endtask

  task automatic next_bit(output logic v);
    do @(posedge i_mclk); while (line_sampled !== 1'b1);
    v = line_bit;
  endtask

  // Waits a bounded time for the first low bit, then collects m bits after it.
  task automatic frame(input int m, output logic [31:0] got);
    logic v;
    int k;
    got = '1;
    k = 0;
    do begin
      next_bit(v);
      k++;
    end while (v !== 1'b0 && k < 64);
    for (int i = 0; i < m; i++) begin
      next_bit(v);
      got[i] = v;
    end
  endtask

  function automatic logic [31:0] exp_frame(input int len, input logic pen, input logic even, input logic [7:0] ch);
    logic [31:0] e;
    logic p;
    e = '1;
    p = ~even;
    for (int i = 0; i < len; i++) begin
      e[i] = ch[i];
      p = p ^ ch[i];
    end
    if (pen) e[len] = p;
    return e;
  endfunction

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // A run needs some four thousand cycles; ten times that means a hang.
  initial begin
    repeat (40000) @(posedge i_mclk);
    err_count++;
    finish_test();
  end

  initial begin
    repeat (6) @(posedge i_mclk);
    #1 i_sys_rst = 1'b0;
    rdc(2'h3, "control_word", 8'h00);
    rdc(2'h2, "format_mode_one", 8'h00);
    rdc(2'h2, "clock_mode_two", 8'h00);
    wr(2'h2, 8'h7D);
    wr(2'h2, 8'h00);
    rdc(2'h3, "control_word", 8'h00);
    rdc(2'h2, "format_mode_one", 8'h7D);
    access(2'h1, 1'b0, 8'h00, q);
    rdc(2'h2, "clock_mode_two", 8'h00);
    rdc(2'h2, "format_mode_one", 8'h7D);
    wr(2'h3, 8'h01);
    // Every length and both parity senses; modes change only while the line is marking.
    for (int c = 0; c < 4; c++) begin
      rdc(2'h3, "control_word", 8'h01);
      wr(2'h2, {2'b01, c[1], c[0], c[1:0], 2'b01});
      wr(2'h2, 8'h00);
      wr(2'h0, chars[c]);
      frame(7 + c + c[0], f);
      check("async_frame", exp_frame(5 + c, c[0], c[1], chars[c]), f);
      check("tx_empty_n", 1'b0, o_tx_empty_or_modem_change_n);
      access(2'h1, 1'b0, 8'h00, q);
      check("line_status", 8'h05, q & 8'h05);
    end
    #1 i_cts_n = 1'b1;
    wr(2'h0, 8'h0F);
    repeat (40) @(posedge i_mclk);
    check("txd", 1'b1, o_txd);
    check("ready_n", 1'b1, o_tx_holding_ready_n);
    #1 i_cts_n = 1'b0;
    frame(10, f);
    check("cts_frame", exp_frame(8, 1'b1, 1'b1, 8'h0F), f);
    wr(2'h3, 8'h09);
    repeat (3) next_bit(b);
    check("break_line", 1'b0, b);
    wr(2'h3, 8'h01);
    repeat (2) next_bit(b);
    check("txd", 1'b1, b);
    wr(2'h1, 8'hFF);
    wr(2'h1, 8'h3C);
    wr(2'h1, 8'h10);
    wr(2'h1, 8'h96);
    // Single, double and transparent fill, then a send-DLE prefix.
    for (int c = 0; c < 4; c++) begin
      wr(2'h3, 8'h00);
      repeat (2) next_bit(b);
      check("txd", 1'b1, b);
      rdc(2'h3, "control_word", 8'h00);
      wr(2'h2, modes[c]);
      wr(2'h2, 8'h00);
      wr(2'h3, cmds[c]);
      repeat (2) next_bit(b);
      check("txd", 1'b1, b);
      check("ready_n", 1'b0, o_tx_holding_ready_n);
      wr(2'h0, 8'hAA);
      frame(23, f);
      check("sync_stream", fills[c], f);
      check("tx_empty_n", 1'b0, o_tx_empty_or_modem_change_n);
    end
    finish_test();
  end
endmodule
`default_nettype wire

// File: hdl/sat_transmitter.v
/*
  Transmit side of a sync/async serial controller with its host register decoder,
  sync/DLE and mode pointers, mode, command and status registers.
  Assumes a host strobing ce_n on the same board; the bit-clock tick input and the
  modem input may be asynchronous and are synchronised here.
*/
//
// Behaviour
// R1 - Transmit only while clear-to-send is low and transmit enable is set.
// R2 - Ready set while holding empty, cleared on write, set again on transfer.
// R3 - Async: start, data LSB first, optional parity, programmed stop bits.
// R4 - Async idle: line high, transmitter-empty asserted until next load.
// R5 - Async break bit drives the line continuously low; here only while idle, so a character loaded during break is still sent.
// R6 - Sync: line high with ready until first load, then continuous characters.
// R7 - Sync underrun: assert empty and fill with sync, sync pair, or DLE-sync.
// R8 - Sync send-DLE bit sends DLE ahead of the holding character.
// R9 - Chip enable low: selects and read/write choose the accessed register.
// R10 - Sync/DLE writes load first sync, second sync, DLE in order.
// R11 - Mode accesses reach mode one first, mode two next.
// R12 - Pointers wrap to the first register past the sequence end.
// R13 - Pointers reset on reset or command read; other accesses leave them.
// R14 - Reset clears mode, command and status registers; the status ready bit still reads one after reset.
// R15 - Format 00 is sync; async factor applies only with external clock.
// R16 - Length field gives 5 to 8 data bits, excluding parity and framing.
// R17 - Parity enable appends parity; type 0 odd, 1 even.
// R18 - Async stop field: 01 one, 10 one and half, 11 two.
// R19 - Sync count bit: set single sync, clear double sync.
// R20 - Transparent mode fills with DLE then first sync.
// R21 - Transparent: DLE loaded sends extra DLE; only one with send-DLE.
// R22 - Host changes length or parity only within allowed bit times.
// R23 - Serial output held high while transmitter disabled.
// R24 - Clear-to-send rising mid-character lets that character finish.
// R25 - Chip enable high: bus undriven, selects ignored.
`timescale 1ns/100ps
`default_nettype none
`include "sat_consts.vh"
module sat_transmitter (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire i_ce_n,
  input wire i_rw,
  input wire i_register_select_high,
  input wire i_register_select_low,
  input wire [7:0] i_data,
  output reg [7:0] o_data,
  output reg o_data_oe,
  input wire i_cts_n,
  input wire i_ext_tick,
  input wire i_int_tick,
  output reg o_txd,
  output reg o_tx_holding_ready_n,
  output reg o_tx_empty_or_modem_change_n
);
  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three stages, a change counts when stages two and three agree.
  reg [2:0] cts_sync_ff;
  reg [2:0] ext_sync_ff;
  reg [2:0] int_sync_ff;
  reg [2:0] ce_sync_ff;
  reg cts_n_ff;
  reg ext_lvl_ff;
  reg int_lvl_ff;
  reg ce_n_ff;
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cts_sync_ff <= 3'h7;
      ext_sync_ff <= 3'h0;
      int_sync_ff <= 3'h0;
      ce_sync_ff <= 3'h7;
      cts_n_ff <= 1'b1;
      ext_lvl_ff <= 1'b0;
      int_lvl_ff <= 1'b0;
      ce_n_ff <= 1'b1;
    end else begin
      cts_sync_ff <= {cts_sync_ff[1:0], i_cts_n};
      ext_sync_ff <= {ext_sync_ff[1:0], i_ext_tick};
      int_sync_ff <= {int_sync_ff[1:0], i_int_tick};
      ce_sync_ff <= {ce_sync_ff[1:0], i_ce_n};
      if (cts_sync_ff[1] == cts_sync_ff[2]) cts_n_ff <= cts_sync_ff[2];
      if (ext_sync_ff[1] == ext_sync_ff[2]) ext_lvl_ff <= ext_sync_ff[2];
      if (int_sync_ff[1] == int_sync_ff[2]) int_lvl_ff <= int_sync_ff[2];
      if (ce_sync_ff[1] == ce_sync_ff[2]) ce_n_ff <= ce_sync_ff[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and pointers.
  reg [7:0] mode_one_ff;
  reg [7:0] mode_two_ff;
  reg [7:0] control_ff;
  reg [7:0] sync1_ff;
  reg [7:0] sync2_ff;
  reg [7:0] dle_ff;
  reg [1:0] sync_ptr_ff;
  reg mode_ptr_ff;
  reg [7:0] holding_ff;
  reg holding_full_ff;
  reg tx_empty_ff;
  reg ce_n_dly_ff;
  wire [1:0] sel = {i_register_select_high, i_register_select_low};
  // An access is taken once, on the synchronised falling edge of chip enable.
  wire access = ce_n_dly_ff & ~ce_n_ff; // R25
  wire wr = access & i_rw; // R9
  wire rd = access & ~i_rw; // R9
  wire is_sync = (mode_one_ff[`SAT_MR1_FMT_HI:`SAT_MR1_FMT_LO] == `SAT_FMT_SYNC); // R15
  wire tx_en = control_ff[`SAT_CR_TRANSMIT_ENABLE_BIT];
  wire brk_dle = control_ff[`SAT_CR_BRKDLE];
  wire transp = mode_one_ff[`SAT_MR1_TRANSP];
  wire status_read = rd & (sel == `SAT_SEL_STAT);
  wire load_hold = wr & (sel == `SAT_SEL_DATA);
  wire take; // Holding to shifter transfer.

  // Status byte: receiver side is absent, so its ready bit reads zero.
  wire [7:0] status = {5'h00, tx_empty_ff, 1'b0, ~holding_full_ff}; // R2

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_one_ff <= `SAT_RESET_BYTE; // R14
      mode_two_ff <= `SAT_RESET_BYTE; // R14
      control_ff <= `SAT_RESET_BYTE; // R14
      sync1_ff <= `SAT_RESET_BYTE;
      sync2_ff <= `SAT_RESET_BYTE;
      dle_ff <= `SAT_RESET_BYTE;
      sync_ptr_ff <= 2'h0; // R13
      mode_ptr_ff <= 1'b0; // R13
      holding_ff <= `SAT_RESET_BYTE;
      holding_full_ff <= 1'b0;
      ce_n_dly_ff <= 1'b1;
      o_data <= `SAT_RESET_BYTE;
      o_data_oe <= 1'b0;
    end else begin
      ce_n_dly_ff <= ce_n_ff;
      o_data_oe <= ~ce_n_ff & ~i_rw; // R25
      // A write landing with a transfer keeps the new character: load wins.
      if (load_hold) begin
        holding_ff <= i_data;
        holding_full_ff <= 1'b1; // R2
      end else if (take) begin
        holding_full_ff <= 1'b0; // R2
      end
      if (wr && sel == `SAT_SEL_STAT) begin
        case (sync_ptr_ff) // R10
          2'h0: sync1_ff <= i_data;
          2'h1: sync2_ff <= i_data;
          default: dle_ff <= i_data;
        endcase
        sync_ptr_ff <= (sync_ptr_ff == `SAT_SYNPTR_LAST) ? 2'h0 : sync_ptr_ff + 2'h1; // R12
      end
      if (access && sel == `SAT_SEL_MODE) begin
        if (i_rw && !mode_ptr_ff) mode_one_ff <= i_data; // R11
        if (i_rw && mode_ptr_ff) mode_two_ff <= i_data; // R11
        o_data <= mode_ptr_ff ? mode_two_ff : mode_one_ff;
        mode_ptr_ff <= ~mode_ptr_ff; // R12
      end
      if (access && sel == `SAT_SEL_CMD) begin
        if (i_rw) begin
          control_ff <= i_data;
        end else begin
          o_data <= control_ff;
          sync_ptr_ff <= 2'h0; // R13
          mode_ptr_ff <= 1'b0; // R13
        end
      end
      if (status_read) o_data <= status;
      if (rd && sel == `SAT_SEL_DATA) o_data <= `SAT_RESET_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bit timing: pick tick source and divide by the async rate factor.
  wire ext_clk = mode_two_ff[`SAT_MR2_CSRC_LO] == 1'b0 && mode_two_ff[`SAT_MR2_CSRC_HI] == 1'b0;
  reg ext_prev_ff;
  reg int_prev_ff;
  wire tick = ext_clk ? (ext_lvl_ff & ~ext_prev_ff) : (int_lvl_ff & ~int_prev_ff);
  reg [6:0] div_ff;
  reg [6:0] nxt_ratio;
  // With the internal clock the async factor is fixed at sixteen.
  always @* begin
    nxt_ratio = `SAT_RATE_16X; // R15
    if (is_sync) nxt_ratio = `SAT_RATE_1X;
    else if (ext_clk) begin
      case (mode_one_ff[`SAT_MR1_FMT_HI:`SAT_MR1_FMT_LO])
        `SAT_FMT_1X: nxt_ratio = `SAT_RATE_1X;
        `SAT_FMT_64X: nxt_ratio = `SAT_RATE_64X;
        default: nxt_ratio = `SAT_RATE_16X;
      endcase
    end
  end
  wire half_tick = tick && (div_ff == {1'b0, nxt_ratio[6:1]} - 7'h1 || nxt_ratio == `SAT_RATE_1X);
  wire bit_tick = tick && (div_ff + 7'h1 >= nxt_ratio);
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ext_prev_ff <= 1'b0;
      int_prev_ff <= 1'b0;
      div_ff <= 7'h00;
    end else begin
      ext_prev_ff <= ext_lvl_ff;
      int_prev_ff <= int_lvl_ff;
      // An async start may launch between bit boundaries, so the divider restarts with it.
      if (bit_tick || (take && !is_sync)) div_ff <= 7'h00;
      else if (tick) div_ff <= div_ff + 7'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shifter state machine.
  localparam ST_IDLE = 4'h1;
  localparam ST_START = 4'h2;
  localparam ST_DATA = 4'h4;
  localparam ST_STOP = 4'h8;
  reg [3:0] state_ff;
  reg [7:0] shift_ff;
  reg [2:0] bit_cnt_ff;
  reg parity_ff;
  reg data_done_ff;
  reg [2:0] stop_half_ff;
  reg started_ff;
  reg pend_dle_ff;
  reg fill_second_ff;
  wire [2:0] len_m1 = {1'b1, mode_one_ff[`SAT_MR1_LEN_HI:`SAT_MR1_LEN_LO]} - 3'h4 + 3'h4; // R16
  wire par_en = mode_one_ff[`SAT_MR1_PEN];

  // Stop length in half bits from the two upper mode bits.
  function [2:0] sat_stop_halves;
    input [1:0] code;
    begin
      case (code) // R18
        `SAT_STOP_ONE: sat_stop_halves = `SAT_STOP_HALVES_1;
        `SAT_STOP_ONE_HALF: sat_stop_halves = `SAT_STOP_HALVES_15;
        `SAT_STOP_TWO: sat_stop_halves = `SAT_STOP_HALVES_2;
        // The invalid code is sent as one stop bit rather than leaving the line stuck.
        default: sat_stop_halves = `SAT_STOP_HALVES_1;
      endcase
    end
  endfunction

  // Initial parity value: odd parity starts at one.
  function sat_par_seed;
    input ptype;
    begin
      sat_par_seed = ~ptype; // R17
    end
  endfunction

  // Clear-to-send high only blocks new characters, never the one in flight.
  wire can_send = tx_en & ~cts_n_ff; // R1 R24
  wire dle_needed = is_sync && (brk_dle || (transp && holding_ff == dle_ff)); // R8 R21
  wire [2:0] stop_halves = sat_stop_halves(mode_one_ff[`SAT_MR1_SCOUNT:`SAT_MR1_TRANSP]); // R18
  // At a 1X factor every tick is a whole bit, so each counts two halves.
  wire [2:0] stop_step = (nxt_ratio == `SAT_RATE_1X) ? `SAT_STOP_STEP_BIT : `SAT_STOP_STEP_HALF;
  // The stop run ends at the very tick that completes it, so a waiting character starts
  // with no extra mark time; async idle launches at the next tick, not at a bit boundary, for the same reason.
  wire stop_done = (state_ff == ST_STOP) && (stop_half_ff != `SAT_STOP_WAIT) && (half_tick || bit_tick)
    && (stop_half_ff + stop_step >= stop_halves); // R18
  wire at_boundary = ((state_ff == ST_IDLE) && (is_sync ? bit_tick : tick)) || stop_done;
  // Fill order: single sync, sync pair, or DLE then first sync in transparent mode.
  wire [7:0] fill_char = (mode_one_ff[`SAT_MR1_SCOUNT] && !transp) ? sync1_ff :
    (!fill_second_ff ? (transp ? dle_ff : sync1_ff) : (transp ? sync1_ff : sync2_ff)); // R7 R19 R20
  // What goes out at the next boundary: a DLE prefix, the held character, or fill.
  wire [7:0] next_char = !holding_full_ff ? fill_char : ((dle_needed && !pend_dle_ff) ? dle_ff : holding_ff);
  wire seed = sat_par_seed(mode_one_ff[`SAT_MR1_PTYPE]); // R17
  assign take = at_boundary && can_send && holding_full_ff && !(dle_needed && !pend_dle_ff);

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= ST_IDLE;
      shift_ff <= `SAT_RESET_BYTE;
      bit_cnt_ff <= 3'h0;
      parity_ff <= 1'b0;
      data_done_ff <= 1'b0;
      stop_half_ff <= 3'h0;
      started_ff <= 1'b0;
      pend_dle_ff <= 1'b0;
      fill_second_ff <= 1'b0;
      tx_empty_ff <= 1'b0;
      o_txd <= 1'b1;
      o_tx_holding_ready_n <= 1'b1;
      o_tx_empty_or_modem_change_n <= 1'b1;
    end else begin
      o_tx_holding_ready_n <= ~(tx_en & ~holding_full_ff & ~load_hold); // R2 R6
      o_tx_empty_or_modem_change_n <= ~tx_empty_ff;
      if (!tx_en) started_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          // Break and the disabled mark act at once; the plain mark waits for a boundary so that
          // a sync stream that just ended a character is not broken by a stray high cycle.
          if (!tx_en) begin
            o_txd <= 1'b1; // R23
          end else if (!is_sync && brk_dle) begin
            o_txd <= 1'b0; // R5
          end else if (at_boundary) begin
            o_txd <= 1'b1; // R4 R6
          end
        end
        ST_START: begin
          // The start bit went out at launch; the first data bit follows at the next bit tick.
          if (bit_tick) begin
            o_txd <= shift_ff[0]; // R3
            parity_ff <= parity_ff ^ shift_ff[0];
            shift_ff <= {1'b0, shift_ff[7:1]};
            bit_cnt_ff <= 3'h1;
            state_ff <= ST_DATA;
          end
        end
        ST_DATA: begin
          // Each bit tick ends one bit and puts the next on the line.
          if (bit_tick) begin
            if (!data_done_ff) begin
              o_txd <= shift_ff[0]; // R3
              parity_ff <= parity_ff ^ shift_ff[0];
              shift_ff <= {1'b0, shift_ff[7:1]};
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
              data_done_ff <= (bit_cnt_ff == len_m1); // R16
            end else begin
              o_txd <= parity_ff; // R17
            end
            // The last bit is now on the line: sync goes straight on, async counts stop time.
            if (data_done_ff || (bit_cnt_ff == len_m1 && !par_en)) begin
              stop_half_ff <= `SAT_STOP_WAIT;
              state_ff <= is_sync ? ST_IDLE : ST_STOP;
            end
          end
        end
        ST_STOP: begin
          // The stop mark begins when the last bit ends; from then on halves are counted.
          if (stop_half_ff == `SAT_STOP_WAIT) begin
            if (bit_tick) begin
              o_txd <= 1'b1; // R3
              stop_half_ff <= 3'h0;
            end
          end else if (half_tick || bit_tick) begin
            stop_half_ff <= stop_half_ff + stop_step; // R18
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
      // Launch at a boundary: a DLE prefix, the held character or a fill. Written after the
      // state code on purpose, so that a launch overrides whatever that code chose.
      if (at_boundary) begin
        data_done_ff <= 1'b0;
        bit_cnt_ff <= 3'h1;
        parity_ff <= seed ^ next_char[0];
        shift_ff <= {1'b0, next_char[7:1]};
        if (can_send && holding_full_ff) begin
          if (dle_needed && !pend_dle_ff) begin
            pend_dle_ff <= 1'b1; // R8 R21
          end else begin
            pend_dle_ff <= 1'b0; // R2
            started_ff <= 1'b1;
            fill_second_ff <= 1'b0;
          end
          if (is_sync) begin
            o_txd <= next_char[0]; // R6
            state_ff <= ST_DATA;
          end else begin
            o_txd <= 1'b0; // R3
            shift_ff <= next_char;
            parity_ff <= seed;
            state_ff <= ST_START;
          end
        end else if (can_send && is_sync && started_ff) begin
          tx_empty_ff <= 1'b1; // R7
          fill_second_ff <= ~fill_second_ff & ~(mode_one_ff[`SAT_MR1_SCOUNT] & ~transp); // R19
          o_txd <= next_char[0]; // R7
          state_ff <= ST_DATA;
        end else begin
          state_ff <= ST_IDLE;
          if (!is_sync && started_ff && !holding_full_ff) tx_empty_ff <= 1'b1; // R4
        end
      end
      // Disabling the transmitter marks the line at once and drops a half-sent character.
      if (!tx_en) begin
        state_ff <= ST_IDLE;
        o_txd <= 1'b1; // R23
        pend_dle_ff <= 1'b0;
        fill_second_ff <= 1'b0;
      end
      // A load in the same cycle as an empty event wins, since the flag means nothing is waiting.
      if (load_hold) tx_empty_ff <= 1'b0; // R4
    end
  end
endmodule
`default_nettype wire

// File: include/sat_consts.vh
/*
  Constants for the serial transmitter block: register selects, field positions,
  stop lengths and rate factors.
  Assumes it is included by bare name from design files.
*/
`ifndef SAT_CONSTS_VH
`define SAT_CONSTS_VH
// Register select values on register_select_high/low.
`define SAT_SEL_DATA 2'h0
`define SAT_SEL_STAT 2'h1
`define SAT_SEL_MODE 2'h2
`define SAT_SEL_CMD 2'h3
// Format mode one field positions.
`define SAT_MR1_FMT_LO 0
`define SAT_MR1_FMT_HI 1
`define SAT_MR1_LEN_LO 2
`define SAT_MR1_LEN_HI 3
`define SAT_MR1_PEN 4
`define SAT_MR1_PTYPE 5
`define SAT_MR1_TRANSP 6
`define SAT_MR1_SCOUNT 7
// Clock mode two clock source bits.
`define SAT_MR2_CSRC_LO 4
`define SAT_MR2_CSRC_HI 5
// Control word bits.
`define SAT_CR_TRANSMIT_ENABLE_BIT 0
`define SAT_CR_BRKDLE 3
// Line status bits.
`define SAT_SR_TX_HOLDING_READY 0
`define SAT_SR_RX_HOLDING_READY 1
`define SAT_SR_TXEMT 2
// Format values.
`define SAT_FMT_SYNC 2'h0
`define SAT_FMT_1X 2'h1
`define SAT_FMT_16X 2'h2
`define SAT_FMT_64X 2'h3
// Sample ticks per bit for each rate factor.
`define SAT_RATE_1X 7'h01
`define SAT_RATE_16X 7'h10
`define SAT_RATE_64X 7'h40
// Stop bit field codes in format mode one.
`define SAT_STOP_ONE 2'h1
`define SAT_STOP_ONE_HALF 2'h2
`define SAT_STOP_TWO 2'h3
// Stop counter marker while the last bit is still on the line, and half-bit steps per count.
`define SAT_STOP_WAIT 3'h7
`define SAT_STOP_STEP_HALF 3'h1
`define SAT_STOP_STEP_BIT 3'h2
`define SAT_STOP_HALVES_1 3'h2
`define SAT_STOP_HALVES_15 3'h3
`define SAT_STOP_HALVES_2 3'h4
// Last sync/DLE pointer value.
`define SAT_SYNPTR_LAST 2'h2
`define SAT_RESET_BYTE 8'h00
`endif
